// ==== common/video_out_pkg.sv ====
//------------------------------------------------------------
// Purpose: Shared constants and types for the video output block
// Assumes: 32-bit APB, 12-bit pixel path
// Notes: Register offsets are byte addresses
//------------------------------------------------------------
package video_out_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_HORIZONTAL_BLANKING = 12'h004;
	localparam logic [11:0] OFS_VERTICAL_BLANKING = 12'h008;
	localparam logic [11:0] OFS_WIDTH = 12'h00c;
	localparam logic [11:0] OFS_HEIGHT = 12'h010;
	localparam logic [11:0] OFS_GAIN_RG = 12'h014;
	localparam logic [11:0] OFS_GAIN_GB = 12'h018;
	localparam logic [11:0] OFS_ROI_START = 12'h01c;
	localparam logic [11:0] OFS_ROI_END = 12'h020;
	localparam logic [11:0] OFS_INTEG = 12'h024;
	localparam logic [11:0] OFS_STATUS = 12'h028;
	localparam logic [11:0] OFS_AE_SUM = 12'h02c;

	// CTRL field positions
	localparam int CTRL_HS_INV = 0;
	localparam int CTRL_VS_INV = 1;
	localparam int CTRL_PCLK_INV = 2;
	localparam int CTRL_WIDTH8 = 3;
	localparam int CTRL_CURVE = 4;
	localparam int CTRL_EMBED = 5;
	localparam int CTRL_PATTERN = 6;
	localparam int CTRL_CFG_ROW = 7;
	localparam int CTRL_ROI_OUT = 8;
	localparam int CTRL_BITS = 9;
	// Packed field positions in two-field registers
	localparam int LO_FIELD = 0;
	localparam int HI_FIELD = 16;
	localparam int STATUS_PEND = 16;

	// ------------------------------------------------------------
	// Widths, reset values, timing
	// ------------------------------------------------------------
	localparam int PIX_W = 12;
	localparam int CNT_W = 14;
	localparam logic [11:0] WIDTH_RESET = 12'h800;
	localparam logic [11:0] HEIGHT_RESET = 12'h600;
	localparam logic [11:0] GAIN_ONE = 12'h100;
	localparam logic [23:0] GAIN_ROUND = 24'h000080;
	localparam logic [CNT_W-1:0] HORIZONTAL_BLANKING_MIN = 14'h0004;
	localparam logic [CNT_W-1:0] VERTICAL_BLANKING_MIN = 14'h0002;
	localparam longint PCLK_MAX_HZ = 48000000;
	localparam longint LINK_CLK_HZ = 12500000;
	localparam longint LINK_PER_PIXEL = 2;
	localparam longint PCLK_HZ = LINK_CLK_HZ / LINK_PER_PIXEL;

	// Colour bars: 75 % and black level, 8-bit values scaled to 12 bits
	localparam logic [11:0] BAR_HI = 12'hb40;
	localparam logic [11:0] BAR_LO = 12'h100;
	localparam logic [7:0] BAR_FRAC = 8'h25;
	localparam logic [2:0] BAR_LAST = 3'h6;

	// Embedded sync codes; in embedded mode pixel data is clamped to [CLAMP_LO, max-1]
	localparam logic [11:0] CODE_SOL = 12'h000;
	localparam logic [11:0] CODE_EOL = 12'h001;
	localparam logic [11:0] CODE_SOF = 12'hfff;
	localparam logic [11:0] CODE_SOF8 = 12'h0ff;
	localparam logic [11:0] CLAMP_LO = 12'h002;
	localparam logic [11:0] MAX12 = 12'hfff;
	localparam logic [11:0] MAX8 = 12'h0ff;

	typedef enum logic [1:0] {
		MARK_NONE = 2'h0,
		MARK_SOL = 2'h1,
		MARK_EOL = 2'h2,
		MARK_SOF = 2'h3
	} mark_t;

	typedef struct packed {
		logic [CTRL_BITS-1:0] ctrl;
		logic [11:0] horizontal_blanking;
		logic [11:0] vertical_blanking;
		logic [11:0] width;
		logic [11:0] height;
		logic [3:0][11:0] gain;
		logic [11:0] roi_c0;
		logic [11:0] roi_r0;
		logic [11:0] roi_c1;
		logic [11:0] roi_r1;
		logic [15:0] integ;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{
		ctrl: 9'h000,
		horizontal_blanking: 12'h000,
		vertical_blanking: 12'h000,
		width: WIDTH_RESET,
		height: HEIGHT_RESET,
		gain: {GAIN_ONE, GAIN_ONE, GAIN_ONE, GAIN_ONE},
		roi_c0: 12'h000,
		roi_r0: 12'h000,
		roi_c1: 12'hfff,
		roi_r1: 12'hfff,
		integ: 16'h0000
	};

endpackage : video_out_pkg

// ==== common/pix_if.sv ====
//------------------------------------------------------------
// Purpose: Pixel stream from the timing generator to the formatter
// Assumes: All signals on the link clock
// Notes: Fields are valid for one pixel slot, taken on step
//------------------------------------------------------------
`timescale 1ns/10ps
interface pix_if;
	logic step;
	logic line_valid;
	logic frame_valid;
	logic [1:0] color;
	logic [11:0] sample;
	video_out_pkg::mark_t mark;
	video_out_pkg::cfg_t cfg;

	modport gen (output step, line_valid, frame_valid, color, sample, mark, cfg);
	modport fmt (input step, line_valid, frame_valid, color, sample, mark, cfg);
endinterface : pix_if

// ==== design/pixel_formatter.sv ====
//------------------------------------------------------------
// Purpose: Gain, width reduction, sync insertion and polarity
// Assumes: Runs on the link clock with a synchronised reset
// Notes: Outputs change only on step, together with the pixel clock edge
//------------------------------------------------------------
`timescale 1ns/10ps
module pixel_formatter (
	input wire logic pix_clk,
	input wire logic prst_n,
	pix_if.fmt p,
	output logic [11:0] data_out,
	output logic hsync_out,
	output logic vsync_out
);

	// ------------------------------------------------------------
	// Gain and reduction
	// ------------------------------------------------------------
	function automatic logic [11:0] apply_gain(input logic [11:0] v, input logic [11:0] g);
		logic [23:0] prod;
		prod = (v * g) + video_out_pkg::GAIN_ROUND;
		return (prod[23:20] != 4'h0) ? video_out_pkg::MAX12 : prod[19:8];
	endfunction : apply_gain

	// Piecewise curve keeps shadow detail; linear mode just drops LSBs
	function automatic logic [11:0] to_eight(input logic [11:0] v, input logic curve);
		logic [11:0] r;
		r = {4'h0, v[11:4]};
		if (curve) begin
			if (v < 12'h200) begin
				r = {6'h00, v[8:3]} + {5'h00, v[8:2]} - {6'h00, v[8:3]};
			end else if (v < 12'h600) begin
				r = 12'h080 + 12'((v - 12'h200) >> 4);
			end else begin
				r = 12'h0c0 + 12'((v - 12'h600) >> 6);
			end
		end
		return r;
	endfunction : to_eight

	wire logic [11:0] gained = apply_gain(p.sample, p.cfg.gain[p.color]);
	wire logic w8 = p.cfg.ctrl[video_out_pkg::CTRL_WIDTH8];
	wire logic embed = p.cfg.ctrl[video_out_pkg::CTRL_EMBED];
	wire logic [11:0] reduced = w8 ? to_eight(gained, p.cfg.ctrl[video_out_pkg::CTRL_CURVE]) : gained;
	wire logic [11:0] top = w8 ? video_out_pkg::MAX8 : video_out_pkg::MAX12;
	// Clamp keeps ordinary pixels off the reserved codes
	wire logic [11:0] clamped = (reduced < video_out_pkg::CLAMP_LO) ? video_out_pkg::CLAMP_LO :
		(reduced == top) ? top - 12'h001 : reduced;
	wire logic [11:0] sof_code = w8 ? video_out_pkg::CODE_SOF8 : video_out_pkg::CODE_SOF;
	wire logic [11:0] embed_word = (p.mark == video_out_pkg::MARK_SOL) ? video_out_pkg::CODE_SOL :
		(p.mark == video_out_pkg::MARK_EOL) ? video_out_pkg::CODE_EOL :
		(p.mark == video_out_pkg::MARK_SOF) ? sof_code :
		p.line_valid ? clamped : video_out_pkg::CLAMP_LO;
	wire logic [11:0] next_data = embed ? embed_word : (p.line_valid ? reduced : 12'h000);
	wire logic hs_level = p.line_valid & ~embed;
	wire logic vs_level = p.frame_valid & ~embed;

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// [R16] same edge update
	always_ff @(posedge pix_clk or negedge prst_n) begin
		if (!prst_n) begin
			data_out <= 12'h000;
			hsync_out <= 1'b0;
			vsync_out <= 1'b0;
		end else if (p.step) begin
			data_out <= next_data;
			// [R01] sync polarity
			hsync_out <= hs_level ^ p.cfg.ctrl[video_out_pkg::CTRL_HS_INV];
			vsync_out <= vs_level ^ p.cfg.ctrl[video_out_pkg::CTRL_VS_INV];
		end
	end

endmodule : pixel_formatter

// ==== design/video_out.sv ====
//------------------------------------------------------------
// Purpose: Image sensor video output port with APB configuration
// Assumes: APB on sys_clk; pixel logic on the link clock pix_clk
// Notes: One pixel per two link clocks; shadowed settings apply at frame start
//------------------------------------------------------------
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Summary of operation
// [R01] Register bits invert the line sync, frame sync and pixel clock outputs.
// [R02] Programmable extra blanking pixels are added to each line and extra rows to each frame.
// [R03] Out of reset the block streams full-resolution video with sync using default settings.
// [R04] The system holds reset low until supplies and the input clock are stable.
// [R05] An enable bit replaces imaged pixels with a colour-bar pattern.
// [R06] The pattern is raw Bayer and passes through the per-colour gain stage.
// [R07] An enable bit replaces row 0 with a row carrying frame number, integration time and more.
// [R08] The exposure region is a rectangle given by upper-left and lower-right row and column.
// [R09] Exposure statistics come from pixels inside or outside the region, as configured.
// [R10] Written settings wait in a shadow and all apply together at the next frame start; writes made during a pending transfer wait for a later frame start.
// [R11] Line and frame sync are generated internally alongside the pixel data.
// [R12] The data port runs at twelve or eight bits, with line sync, frame sync and pixel clock.
// [R13] Eight-bit output uses a fixed curve or a linear mapping, as selected.
// [R14] Embedded-sync mode marks line and frame timing with reserved codes in the data.
// [R15] The pixel clock stays at or below forty-eight megahertz, one word per cycle.
// [R16] Data and sync outputs change on the same pixel clock edge.
// [R17] Sync codes are constants that clamped pixel data never reaches.
module video_out (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pix_clk,
	input wire logic [11:0] sensor_data,
	output logic pclk_out,
	output logic hsync_out,
	output logic vsync_out,
	output logic [11:0] data_out
);

	// ------------------------------------------------------------
	// APB register file (sys_clk)
	// ------------------------------------------------------------
	video_out_pkg::cfg_t live;
	video_out_pkg::cfg_t snap;
	logic cfg_req;
	logic ack_s1;
	logic ack_s2;
	logic [15:0] st_frame;
	logic [31:0] st_sum;
	logic stt_s1;
	logic stt_s2;
	logic stt_s3;
	logic prst_s1;
	logic prst_n;
	logic req_s1;
	logic req_s2;
	logic cfg_ack;
	video_out_pkg::cfg_t act;
	localparam int CNT_W_L = video_out_pkg::CNT_W;
	logic phase;
	logic [CNT_W_L-1:0] col;
	logic [CNT_W_L-1:0] row;
	logic [11:0] bar_cnt;
	logic [2:0] bar_idx;
	logic [15:0] frame_no;
	logic [31:0] acc;
	logic [15:0] pub_frame;
	logic [31:0] pub_sum;
	logic stat_tog;

	wire logic setup = psel & ~penable;
	wire logic wr_en = psel & penable & pwrite & pready;
	wire logic [15:0] wlo = pwdata[15:0];
	wire logic [11:0] wlo12 = pwdata[11:0];
	wire logic [11:0] whi12 = pwdata[27:16];
	wire logic busy = cfg_req != ack_s2;
	wire logic pend = busy | (live != snap);
	wire logic hit = (paddr == video_out_pkg::OFS_CTRL) || (paddr == video_out_pkg::OFS_HORIZONTAL_BLANKING) ||
		(paddr == video_out_pkg::OFS_VERTICAL_BLANKING) || (paddr == video_out_pkg::OFS_WIDTH) ||
		(paddr == video_out_pkg::OFS_HEIGHT) || (paddr == video_out_pkg::OFS_GAIN_RG) ||
		(paddr == video_out_pkg::OFS_GAIN_GB) || (paddr == video_out_pkg::OFS_ROI_START) ||
		(paddr == video_out_pkg::OFS_ROI_END) || (paddr == video_out_pkg::OFS_INTEG) ||
		(paddr == video_out_pkg::OFS_STATUS) || (paddr == video_out_pkg::OFS_AE_SUM);

	function automatic logic [31:0] pair(input logic [11:0] lo, input logic [11:0] hi);
		return {4'h0, hi, 4'h0, lo};
	endfunction : pair

	logic [31:0] rd_word;
	always_comb begin
		unique case (paddr)
			video_out_pkg::OFS_CTRL: rd_word = {23'h000000, live.ctrl};
			video_out_pkg::OFS_HORIZONTAL_BLANKING: rd_word = {20'h00000, live.horizontal_blanking};
			video_out_pkg::OFS_VERTICAL_BLANKING: rd_word = {20'h00000, live.vertical_blanking};
			video_out_pkg::OFS_WIDTH: rd_word = {20'h00000, live.width};
			video_out_pkg::OFS_HEIGHT: rd_word = {20'h00000, live.height};
			video_out_pkg::OFS_GAIN_RG: rd_word = pair(live.gain[0], live.gain[1]);
			video_out_pkg::OFS_GAIN_GB: rd_word = pair(live.gain[2], live.gain[3]);
			video_out_pkg::OFS_ROI_START: rd_word = pair(live.roi_c0, live.roi_r0);
			video_out_pkg::OFS_ROI_END: rd_word = pair(live.roi_c1, live.roi_r1);
			video_out_pkg::OFS_INTEG: rd_word = {16'h0000, live.integ};
			video_out_pkg::OFS_STATUS: rd_word = {15'h0000, pend, st_frame};
			video_out_pkg::OFS_AE_SUM: rd_word = st_sum;
			default: rd_word = 32'h00000000;
		endcase
	end

	// Answer is registered in setup, so every access has zero wait states
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit;
			prdata <= (setup & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	// [R03] default settings
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			live <= video_out_pkg::CFG_RESET;
		end else if (wr_en) begin
			unique case (paddr)
				video_out_pkg::OFS_CTRL: live.ctrl <= pwdata[video_out_pkg::CTRL_BITS-1:0];
				// [R02] extra blanking
				video_out_pkg::OFS_HORIZONTAL_BLANKING: live.horizontal_blanking <= wlo12;
				video_out_pkg::OFS_VERTICAL_BLANKING: live.vertical_blanking <= wlo12;
				video_out_pkg::OFS_WIDTH: live.width <= wlo12;
				video_out_pkg::OFS_HEIGHT: live.height <= wlo12;
				video_out_pkg::OFS_GAIN_RG: live.gain[1:0] <= {whi12, wlo12};
				video_out_pkg::OFS_GAIN_GB: live.gain[3:2] <= {whi12, wlo12};
				// [R08] region corners
				video_out_pkg::OFS_ROI_START: {live.roi_r0, live.roi_c0} <= {whi12, wlo12};
				video_out_pkg::OFS_ROI_END: {live.roi_r1, live.roi_c1} <= {whi12, wlo12};
				video_out_pkg::OFS_INTEG: live.integ <= wlo;
				default: live <= live;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Settings handshake to the link domain
	// ------------------------------------------------------------
	// Snapshot is frozen while a request is open, so the far side reads stable bits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			snap <= video_out_pkg::CFG_RESET;
			cfg_req <= 1'b0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= cfg_ack;
			ack_s2 <= ack_s1;
			// [R10] shadow copy
			if (!busy && (live != snap)) begin
				snap <= live;
				cfg_req <= ~cfg_req;
			end
		end
	end

	// Status words are stable for a whole frame after their toggle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stt_s1 <= 1'b0;
			stt_s2 <= 1'b0;
			stt_s3 <= 1'b0;
			st_frame <= 16'h0000;
			st_sum <= 32'h00000000;
		end else begin
			stt_s1 <= stat_tog;
			stt_s2 <= stt_s1;
			stt_s3 <= stt_s2;
			if (stt_s2 != stt_s3) begin
				st_frame <= pub_frame;
				st_sum <= pub_sum;
			end
		end
	end

	// ------------------------------------------------------------
	// Link domain reset and handshake
	// ------------------------------------------------------------
	always_ff @(posedge pix_clk or negedge rst_n) begin
		if (!rst_n) begin
			prst_s1 <= 1'b0;
			prst_n <= 1'b0;
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end else begin
			prst_s1 <= 1'b1;
			prst_n <= prst_s1;
			req_s1 <= cfg_req;
			req_s2 <= req_s1;
		end
	end

	// ------------------------------------------------------------
	// Pixel timing (pix_clk)
	// ------------------------------------------------------------

	// [R02] line and frame totals
	wire logic [CNT_W_L-1:0] line_total = CNT_W_L'(act.width) + video_out_pkg::HORIZONTAL_BLANKING_MIN + CNT_W_L'(act.horizontal_blanking);
	wire logic [CNT_W_L-1:0] frame_total = CNT_W_L'(act.height) + video_out_pkg::VERTICAL_BLANKING_MIN + CNT_W_L'(act.vertical_blanking);
	// [R15] one word per two link clocks
	wire logic step = phase;
	wire logic line_end = col == line_total - 14'h0001;
	wire logic frame_end = line_end && (row == frame_total - 14'h0001);
	wire logic [CNT_W_L-1:0] next_row = frame_end ? 14'h0000 : (line_end ? row + 14'h0001 : row);
	wire logic [CNT_W_L-1:0] next_col = line_end ? 14'h0000 : col + 14'h0001;
	wire logic frame_valid = row < CNT_W_L'(act.height);
	wire logic line_valid = frame_valid && (col < CNT_W_L'(act.width));
	wire logic cfg_line = act.ctrl[video_out_pkg::CTRL_CFG_ROW] && (row == 14'h0000);
	wire logic [19:0] bar_prod = act.width * video_out_pkg::BAR_FRAC;
	wire logic [11:0] bar_w = (bar_prod[19:8] == 12'h000) ? 12'h001 : bar_prod[19:8];

	// [R14] sync marks at the blanking edges of each active line
	wire logic sol = line_end && (next_row < CNT_W_L'(act.height));
	wire logic eol = frame_valid && (col == CNT_W_L'(act.width));
	wire video_out_pkg::mark_t mark = sol ? ((next_row == 14'h0000) ? video_out_pkg::MARK_SOF :
		video_out_pkg::MARK_SOL) : (eol ? video_out_pkg::MARK_EOL : video_out_pkg::MARK_NONE);

	// [R05] colour bar lookup, red green blue flags
	function automatic logic [2:0] bar_rgb(input logic [2:0] idx);
		logic [2:0] r;
		r = 3'h0;
		unique case (idx)
			3'h0: r = 3'h7;
			3'h1: r = 3'h6;
			3'h2: r = 3'h3;
			3'h3: r = 3'h2;
			3'h4: r = 3'h5;
			3'h5: r = 3'h4;
			3'h6: r = 3'h1;
			default: r = 3'h0;
		endcase
		return r;
	endfunction : bar_rgb

	// [R06] raw Bayer: even rows R Gr, odd rows Gb B
	wire logic [1:0] color = {row[0], col[0]};
	wire logic [2:0] rgb = bar_rgb(bar_idx);
	wire logic bar_on = (color == 2'h0) ? rgb[2] : (color == 2'h3) ? rgb[0] : rgb[1];
	wire logic [11:0] bar_sample = bar_on ? video_out_pkg::BAR_HI : video_out_pkg::BAR_LO;

	// [R07] configuration row words
	logic [11:0] cfg_word;
	always_comb begin
		unique case (col)
			14'h0000: cfg_word = frame_no[11:0];
			14'h0001: cfg_word = {8'h00, frame_no[15:12]};
			14'h0002: cfg_word = act.integ[11:0];
			14'h0003: cfg_word = {8'h00, act.integ[15:12]};
			14'h0004: cfg_word = act.width;
			14'h0005: cfg_word = act.height;
			default: cfg_word = 12'h000;
		endcase
	end

	wire logic [11:0] sample = cfg_line ? cfg_word :
		(act.ctrl[video_out_pkg::CTRL_PATTERN] ? bar_sample : sensor_data);

	// [R09] region membership, inside or outside
	wire logic in_roi = (col >= CNT_W_L'(act.roi_c0)) && (col <= CNT_W_L'(act.roi_c1)) &&
		(row >= CNT_W_L'(act.roi_r0)) && (row <= CNT_W_L'(act.roi_r1));
	wire logic take_stat = line_valid && !cfg_line && (in_roi ^ act.ctrl[video_out_pkg::CTRL_ROI_OUT]);

	always_ff @(posedge pix_clk or negedge prst_n) begin
		if (!prst_n) begin
			phase <= 1'b0;
			pclk_out <= 1'b0;
		end else begin
			phase <= ~phase;
			// [R01] pixel clock polarity
			pclk_out <= phase ^ act.ctrl[video_out_pkg::CTRL_PCLK_INV];
		end
	end

	// [R11] internal sync counters
	always_ff @(posedge pix_clk or negedge prst_n) begin
		if (!prst_n) begin
			col <= 14'h0000;
			row <= 14'h0000;
			bar_cnt <= 12'h000;
			bar_idx <= 3'h0;
		end else if (step) begin
			col <= next_col;
			row <= next_row;
			if (line_end) begin
				bar_cnt <= 12'h000;
				bar_idx <= 3'h0;
			end else if (bar_cnt == bar_w - 12'h001) begin
				bar_cnt <= 12'h000;
				bar_idx <= (bar_idx == video_out_pkg::BAR_LAST) ? bar_idx : bar_idx + 3'h1;
			end else begin
				bar_cnt <= bar_cnt + 12'h001;
			end
		end
	end

	// [R10] settings apply at frame start
	always_ff @(posedge pix_clk or negedge prst_n) begin
		if (!prst_n) begin
			cfg_ack <= 1'b0;
			act <= video_out_pkg::CFG_RESET;
		end else begin
			if ((step ? frame_end : ~|{frame_no, row, col}) && (req_s2 != cfg_ack)) begin
				act <= snap;
				cfg_ack <= req_s2;
			end
		end
	end

	// [R09] exposure statistics
	always_ff @(posedge pix_clk or negedge prst_n) begin
		if (!prst_n) begin
			acc <= 32'h00000000;
			frame_no <= 16'h0000;
			pub_frame <= 16'h0000;
			pub_sum <= 32'h00000000;
			stat_tog <= 1'b0;
		end else if (step) begin
			if (frame_end) begin
				pub_frame <= frame_no;
				pub_sum <= acc;
				stat_tog <= ~stat_tog;
				frame_no <= frame_no + 16'h0001;
				acc <= 32'h00000000;
			end else if (take_stat) begin
				acc <= acc + {24'h000000, sample[11:4]};
			end
		end
	end

	// ------------------------------------------------------------
	// Formatter
	// ------------------------------------------------------------
	pix_if px ();

	assign px.step = step;
	assign px.line_valid = line_valid;
	assign px.frame_valid = frame_valid;
	assign px.color = color;
	assign px.sample = sample;
	assign px.mark = mark;
	assign px.cfg = act;

	// [R12] [R13] [R17] width, curve and clamping
	pixel_formatter u_fmt (
		.pix_clk(pix_clk),
		.prst_n(prst_n),
		.p(px.fmt),
		.data_out(data_out),
		.hsync_out(hsync_out),
		.vsync_out(vsync_out)
	);

endmodule : video_out

// ==== verif/video_out_sva.sv ====
//------------------------------------------------------------
// Purpose: Port checks for video_out
// Assumes: One-cycle APB answer, pixel slot of two pix_clk
// Notes: Bound below
//------------------------------------------------------------
`timescale 1ns/10ps
module video_out_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pix_clk,
	input wire logic pclk_out,
	input wire logic hsync_out,
	input wire logic [11:0] data_out
);
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_ready_next; @(posedge sys_clk) disable iff (!rst_n) psel && !penable |=> pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("no pready");
	property p_ready_once; @(posedge sys_clk) disable iff (!rst_n) pready |=> !pready; endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready held");
	property p_err_ready; @(posedge sys_clk) disable iff (!rst_n) pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
	property p_idle_zero; @(posedge sys_clk) disable iff (!rst_n) !pready |-> prdata == 32'h0; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("prdata idle");
	property p_unmapped;
		@(posedge sys_clk) disable iff (!rst_n) psel && !penable && paddr > 12'h02c |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no pslverr");
	// Data and line sync move only with the pixel clock
	property p_data_edge;
		@(posedge pix_clk) disable iff (!rst_n) $changed(data_out) || $changed(hsync_out) |-> $changed(pclk_out);
	endproperty
	a_data_edge: assert property (p_data_edge) else $error("data off edge");
	property p_one_word; @(posedge pix_clk) disable iff (!rst_n) $changed(data_out) |=> $stable(data_out); endproperty
	a_one_word: assert property (p_one_word) else $error("word too short");
	// A phase flip at frame start may stretch one period
	property p_pclk_rate; @(posedge pix_clk) disable iff (!rst_n) $rose(pclk_out) |-> ##[2:3] $rose(pclk_out); endproperty
	a_pclk_rate: assert property (p_pclk_rate) else $error("pclk rate");
endmodule : video_out_sva

bind video_out video_out_sva i_sva (.*);

// ==== verif/video_rx.sv ====
//------------------------------------------------------------
// Purpose: Downstream video receiver model
// Assumes: One word per pclk_out period
// Notes: Measures line and frame timing, keeps row 0 words
//------------------------------------------------------------
`timescale 1ns/10ps
module video_rx (
	input wire logic pix_clk,
	input wire logic pclk_out,
	input wire logic hsync_out,
	input wire logic vsync_out,
	input wire logic [11:0] data_out,
	input wire logic [2:0] inv,
	input wire logic embed,
	output logic [15:0] act_len,
	output logic [15:0] line_per,
	output logic [15:0] frame_per,
	output logic [15:0] w0,
	output logic [15:0] w4
);
	// ------------------------------------------------------------
	// Slot sampling
	// ------------------------------------------------------------
	logic hs_q = 0, vs_q = 0, top = 0, pend = 0;
	logic [11:0] last = '0;
	logic [15:0] act = '0, lc = '0, fc = '0, col = '0;
	wire hs = hsync_out ^ inv[0];
	wire vs = vsync_out ^ inv[1];
	wire sof = last == video_out_pkg::CODE_SOF;
	wire ls = embed ? (last == video_out_pkg::CODE_SOL || sof) : hs && !hs_q;
	wire fs = embed ? sof : vs && !vs_q;
	always @(posedge pix_clk) begin
		if (pclk_out ^ inv[2]) begin
			hs_q <= hs;
			vs_q <= vs;
			last <= data_out;
			act <= hs ? act + 16'h1 : 16'h0;
			lc <= ls ? 16'h1 : lc + 16'h1;
			fc <= fs ? 16'h1 : fc + 16'h1;
			col <= ls ? 16'h1 : col + 16'h1;
			pend <= !ls && (fs || pend);
			top <= ls ? (fs || pend) : top;
			if (hs_q && !hs)
				act_len <= act;
			if (ls && top)
				line_per <= lc;
			if (fs)
				frame_per <= fc;
			if (ls && (fs || pend))
				w0 <= {4'h0, data_out};
			if (top && col == 16'h4)
				w4 <= {4'h0, data_out};
		end
	end
endmodule : video_rx

// ==== verif/test_video_out.sv ====
//------------------------------------------------------------
// Purpose: Self-checking bench for video_out
// Assumes: Only the first setting written before video starts applies to frame one; the rest apply to frame two
// Notes: 16x4 frames keep the run short
//------------------------------------------------------------
`timescale 1ns/10ps
module test_video_out;
	logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pix_clk = 0, pix_run = 1, embed = 0, e;
	logic [11:0] paddr = '0, sensor_data = 12'h923, data_out;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, pclk_out, hsync_out, vsync_out;
	logic [15:0] act_len, line_per, frame_per, w0, w4;
	logic [2:0] inv = '0;
	int err_total = 0, samples_checked = 0, cyc = 0, n;
	logic [31:0] rv [10] = '{0, 0, 0, 32'h800, 32'h600, 32'h01000100, 32'h01000100, 0, 32'h0fff0fff, 0};
	video_out i_dut (.*);
	video_rx i_rx (.*);
	always #50 sys_clk = ~sys_clk;
	always #40 if (pix_run) pix_clk = ~pix_clk;
	always @(posedge sys_clk) if (++cyc == 60000) begin
		err_total++;
		close_out();
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_vid(input logic [15:0] got, input logic [15:0] exp);
		chk_reg({16'h0, got}, {16'h0, exp});
	endtask : chk_vid
	// Hold the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1 && ++k < 9);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge sys_clk);
	endtask : apb
	task automatic phase(input logic [31:0] ctrl);
		apb(1, 12'h000, ctrl);
		repeat (900) @(posedge sys_clk);
	endtask : phase
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1;
		for (int i = 0; i < 10; i++) begin
			apb(0, 12'(i * 4), 0);
			chk_reg(q, rv[i]);
		end
		apb(0, 12'h030, 0);
		chk_reg({e, q[30:0]}, 32'h80000000);
		n = 0;
		while (act_len !== 16'h800 && n++ < 12000) @(posedge sys_clk);
		chk_vid(act_len, 16'h800);
		chk_vid(w0, 16'h923);
		// Link clock held while settings are written
		rst_n <= 0;
		repeat (4) @(posedge sys_clk);
		pix_run <= 0;
		@(posedge sys_clk);
		rst_n <= 1;
		apb(1, 12'h010, 4);
		apb(1, 12'h00c, 16);
		apb(1, 12'h004, 3);
		apb(1, 12'h008, 1);
		apb(1, 12'h020, 0);
		apb(0, 12'h028, 0);
		chk_reg(q & 32'h10000, 32'h10000);
		pix_run <= 1;
		n = 0;
		while (frame_per !== 16'h00a1 && n++ < 30000) @(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
		chk_vid(act_len, 16);
		chk_vid(line_per, 23);
		chk_vid(frame_per, 161);
		chk_vid(w0, 16'h923);
		apb(0, 12'h02c, 0);
		chk_reg(q, 32'h92);
		apb(0, 12'h028, 0);
		chk_reg(q & 32'h10000, 0);
		phase(32'h080);
		chk_vid(w4, 16'h010);
		apb(1, 12'h014, 32'h01000080);
		phase(32'h100);
		chk_vid(w0, 16'h492);
		apb(0, 12'h02c, 0);
		chk_reg(q, 32'h23ee);
		phase(32'h040);
		chk_vid(w0, 16'h5a0);
		chk_vid(w4, 16'h080);
		embed <= 1;
		phase(32'h020);
		chk_vid(w0, 16'h492);
		chk_vid(line_per, 23);
		embed <= 0;
		phase(32'h008);
		chk_vid(w0, 16'h049);
		phase(32'h018);
		chk_vid(w0, 16'h0a9);
		inv <= 3'h7;
		phase(32'h007);
		chk_vid(act_len, 16);
		chk_vid(w0, 16'h492);
		close_out();
	end
endmodule : test_video_out
